// ### dmsei_pkg.sv
// Constants and types shared by the dual mode serial memory interface
package dmsei_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Memory organisation
   localparam int          MEM_DEPTH   = 128;
   localparam int          ADDR_W      = 7;
   localparam int          DATA_W      = 8;
   localparam int          PAGE_W      = 3;
   localparam logic [6:0]  ADDR_FIRST  = 7'h00;
   localparam logic [6:0]  ADDR_STEP   = 7'h01;
   localparam logic [2:0]  PAGE_STEP   = 3'h1;

   ////////////////////////////////////////////////////////////////////////////
   // Device select: type code value is arbitrary
   localparam logic [3:0]  DEV_TYPE    = 4'h6;
   localparam int          DEV_HI      = 7;
   localparam int          DEV_LO      = 4;
   localparam int          RW_BIT      = 0;
   localparam int          MSB         = 7;

   ////////////////////////////////////////////////////////////////////////////
   // Bit counting
   localparam logic [3:0]  INIT_PULSES = 4'h9;
   localparam logic [3:0]  TX_LAST_BIT = 4'h8;
   localparam logic [3:0]  ACK_BIT     = 4'h8;
   localparam logic [3:0]  BYTE_DONE   = 4'h9;
   localparam logic [3:0]  CNT_ZERO    = 4'h0;
   localparam logic [3:0]  CNT_STEP    = 4'h1;

   ////////////////////////////////////////////////////////////////////////////
   // Recovery and programming timing
   localparam int          CLK_HZ         = 10_000_000;
   localparam int          RECOV_TIME_MS  = 2000;
   localparam int          RECOV_CYC_DFLT = RECOV_TIME_MS * (CLK_HZ / 1000);
   localparam int          TIMER_W        = 25;
   localparam logic [7:0]  RECOV_PULSES   = 8'h80;
   localparam logic [7:0]  PULSE_STEP     = 8'h01;
   localparam int          PROG_CYC_DFLT  = 100;
   localparam int          PROG_W         = 16;

   ////////////////////////////////////////////////////////////////////////////
   // Modes and bus phases
   typedef enum logic [1:0] {
      MODE_TX,
      MODE_TRANS,
      MODE_BUS
   } dmsei_mode_t;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_DEV,
      PH_ADDR,
      PH_WDATA,
      PH_READ
   } dmsei_phase_t;

endpackage

// ### dmsei_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module dmsei_sync #(
   parameter int W = 4
) (
   // Clock and reset
   input  wire logic         core_clk_in,
   input  wire logic         rstn_in,
   // Asynchronous levels
   input  wire logic [W-1:0] async_in,
   // Synchronised levels
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         meta     <= '0;
         sync_out <= '0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule // dmsei_sync

// ### dmsei_core.sv
// Transmit-only stream and two-wire slave logic of the serial memory
`timescale 1ns/10ps

// Behaviour
// - Power-up in stream mode, advance on clock rise
// - First nine stream clocks leave data released
// - Tenth rise drives MSB of location zero
// - Nine clocks per byte, ninth don't care
// - Stream bytes consecutively with address increment
// - 128 bytes, address wraps to zero
// - Bus clock fall enters bidirectional mode
// - Plain variant never returns to stream mode
// - Recovery variant passes through transition state
// - Stream clock pin level gates writes
// - Write control pin level gates writes
// - Select byte MSB first, type, don't care, direction
// - Slave only; START, select, direction, acknowledge
// - Acknowledge each received byte in ninth bit, except a select byte of another type or while programming is busy
// - Current, random and sequential reads supported
// - Byte write and page write of eight
// - Reset disables all operation and commands
// - Transition expires after 128 pulses or timeout
// - Valid select locks bus mode
// - Bus clock fall restarts transition counters
module dmsei_core #(
   parameter bit ERR_RECOVERY = 1'b1,
   parameter bit WE_ON_TRANSMIT_ONLY_CLOCK   = 1'b1,
   parameter int RECOV_CYCLES = dmsei_pkg::RECOV_CYC_DFLT,
   parameter int PROG_CYCLES  = dmsei_pkg::PROG_CYC_DFLT
) (
   // Clock and power-on reset
   input  wire logic core_clk_in,
   input  wire logic rstn_in,
   // Two-wire bus pins
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe_out,
   // Stream clock and write control pins
   input  wire logic transmit_only_clock_in,
   input  wire logic write_control_input_in,
   // Status
   output logic      bus_mode_out,
   output logic      prog_busy_out
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      dmsei_pkg::dmsei_mode_t             mode;
      dmsei_pkg::dmsei_phase_t            phase;
      logic [3:0]                         bitcnt;
      logic [7:0]                         shift;
      logic [7:0]                         obyte;
      logic                               oe;
      logic                               mack;
      logic [6:0]                         addr;
      logic                               wr_pend;
      logic                               busy;
      logic [dmsei_pkg::PROG_W-1:0]       prog_cnt;
      logic [3:0]                         tx_init;
      logic [3:0]                         tx_bit;
      logic [6:0]                         tx_addr;
      logic [7:0]                         tx_byte;
      logic [7:0]                         vcount;
      logic [dmsei_pkg::TIMER_W-1:0]      rtimer;
      logic                               scl_q;
      logic                               sda_q;
      logic                               transmit_only_clock_q;
   } dmsei_state_t;

   localparam logic [dmsei_pkg::TIMER_W-1:0] RECOV_LAST =
      dmsei_pkg::TIMER_W'(RECOV_CYCLES - 1);
   localparam logic [dmsei_pkg::PROG_W-1:0]  PROG_LAST  =
      dmsei_pkg::PROG_W'(PROG_CYCLES - 1);

   dmsei_state_t st;
   dmsei_state_t next_st;
   logic [7:0]   mem [dmsei_pkg::MEM_DEPTH];
   logic [3:0]   sync_lvl;
   logic         scl_s;
   logic         sda_s;
   logic         transmit_only_clock_s;
   logic         wc_s;
   logic         scl_rise;
   logic         scl_fall;
   logic         transmit_only_clock_rise;
   logic         start_det;
   logic         stop_det;
   logic         wr_allow;
   logic         mem_we;
   logic         expire;

   function automatic logic dev_match(input logic [7:0] sel);
      dev_match = (sel[dmsei_pkg::DEV_HI:dmsei_pkg::DEV_LO]
                   == dmsei_pkg::DEV_TYPE);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   dmsei_sync #(
      .W (4)
   ) u_sync (
      .core_clk_in (core_clk_in),
      .rstn_in     (rstn_in),
      .async_in    ({scl_in, sda_in, transmit_only_clock_in,
                     write_control_input_in}),
      .sync_out    (sync_lvl)
   );

   assign scl_s     = sync_lvl[3];
   assign sda_s     = sync_lvl[2];
   assign transmit_only_clock_s    = sync_lvl[1];
   assign wc_s      = sync_lvl[0];
   assign scl_rise  = scl_s & ~st.scl_q;
   assign scl_fall  = ~scl_s & st.scl_q;
   assign transmit_only_clock_rise = transmit_only_clock_s & ~st.transmit_only_clock_q;
   // Data only changes while clock is low, so these are true conditions
   assign start_det = scl_s & st.scl_q & st.sda_q & ~sda_s;
   assign stop_det  = scl_s & st.scl_q & ~st.sda_q & sda_s;
   assign wr_allow  = WE_ON_TRANSMIT_ONLY_CLOCK ? transmit_only_clock_s : wc_s;
   assign expire    = (transmit_only_clock_rise
                       && st.vcount == dmsei_pkg::RECOV_PULSES
                          - dmsei_pkg::PULSE_STEP)
                      || st.rtimer == RECOV_LAST;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic [7:0] cur_byte;
      cur_byte = 8'h00;
      next_st  = st;
      mem_we   = 1'b0;
      next_st.scl_q  = scl_s;
      next_st.sda_q  = sda_s;
      next_st.transmit_only_clock_q = transmit_only_clock_s;

      // Programming cycle timer
      if (st.busy) begin
         next_st.prog_cnt = st.prog_cnt + 1'b1;
         if (st.prog_cnt == PROG_LAST) begin
            next_st.busy = 1'b0;
         end
      end

      case (st.mode)
         dmsei_pkg::MODE_TX: begin
            if (scl_fall) begin
               // Released before any bus activity is decoded
               next_st.mode   = ERR_RECOVERY ? dmsei_pkg::MODE_TRANS
                                             : dmsei_pkg::MODE_BUS;
               next_st.oe     = 1'b0;
               next_st.phase  = dmsei_pkg::PH_IDLE;
               next_st.bitcnt = dmsei_pkg::CNT_ZERO;
               next_st.vcount = '0;
               next_st.rtimer = '0;
            end else if (transmit_only_clock_rise) begin
               if (st.tx_init < dmsei_pkg::INIT_PULSES) begin
                  next_st.tx_init = st.tx_init + dmsei_pkg::CNT_STEP;
               end else begin
                  if (st.tx_bit == dmsei_pkg::CNT_ZERO) begin
                     cur_byte        = mem[st.tx_addr];
                     next_st.tx_addr = st.tx_addr
                                       + dmsei_pkg::ADDR_STEP;
                  end else begin
                     cur_byte = st.tx_byte;
                  end
                  if (st.tx_bit == dmsei_pkg::TX_LAST_BIT) begin
                     next_st.oe     = 1'b0;
                     next_st.tx_bit = dmsei_pkg::CNT_ZERO;
                  end else begin
                     next_st.oe      = ~cur_byte[dmsei_pkg::MSB];
                     next_st.tx_byte = {cur_byte[6:0], 1'b0};
                     next_st.tx_bit  = st.tx_bit + dmsei_pkg::CNT_STEP;
                  end
               end
            end
         end
         dmsei_pkg::MODE_TRANS: begin
            if (scl_fall) begin
               next_st.vcount = '0;
               next_st.rtimer = '0;
            end else if (expire) begin
               // Stream resumes at the next byte boundary
               next_st.mode   = dmsei_pkg::MODE_TX;
               next_st.oe     = 1'b0;
               next_st.phase  = dmsei_pkg::PH_IDLE;
               next_st.tx_bit = dmsei_pkg::CNT_ZERO;
            end else begin
               next_st.rtimer = st.rtimer + 1'b1;
               if (transmit_only_clock_rise) begin
                  next_st.vcount = st.vcount + dmsei_pkg::PULSE_STEP;
               end
            end
         end
         dmsei_pkg::MODE_BUS: begin
            next_st.mode = dmsei_pkg::MODE_BUS;
         end
         default: begin
            next_st.mode = dmsei_pkg::MODE_TX;
         end
      endcase

      //////////////////////////////////////////////////////////////////////////
      // Two-wire slave engine, also active in the transition state
      if (st.mode != dmsei_pkg::MODE_TX
          && next_st.mode != dmsei_pkg::MODE_TX) begin
         if (start_det) begin
            next_st.phase  = dmsei_pkg::PH_DEV;
            next_st.bitcnt = dmsei_pkg::CNT_ZERO;
            next_st.oe     = 1'b0;
         end else if (stop_det) begin
            next_st.phase = dmsei_pkg::PH_IDLE;
            next_st.oe    = 1'b0;
            if (st.wr_pend) begin
               next_st.busy     = 1'b1;
               next_st.prog_cnt = '0;
               next_st.wr_pend  = 1'b0;
            end
         end else if (st.phase != dmsei_pkg::PH_IDLE) begin
            if (scl_rise) begin
               if (st.bitcnt < dmsei_pkg::ACK_BIT) begin
                  next_st.shift = {st.shift[6:0], sda_s};
               end else if (st.bitcnt == dmsei_pkg::ACK_BIT) begin
                  next_st.mack = ~sda_s;
               end
               if (st.bitcnt != dmsei_pkg::BYTE_DONE) begin
                  next_st.bitcnt = st.bitcnt + dmsei_pkg::CNT_STEP;
               end
            end else if (scl_fall) begin
               if (st.bitcnt == dmsei_pkg::ACK_BIT) begin
                  if (st.phase == dmsei_pkg::PH_READ) begin
                     next_st.oe = 1'b0;
                  end else if (st.phase == dmsei_pkg::PH_DEV) begin
                     next_st.oe = dev_match(st.shift) && !st.busy;
                  end else begin
                     next_st.oe = 1'b1;
                  end
               end else if (st.bitcnt == dmsei_pkg::BYTE_DONE) begin
                  next_st.bitcnt = dmsei_pkg::CNT_ZERO;
                  next_st.oe     = 1'b0;
                  case (st.phase)
                     dmsei_pkg::PH_DEV: begin
                        if (dev_match(st.shift) && !st.busy) begin
                           next_st.mode = dmsei_pkg::MODE_BUS;
                           if (st.shift[dmsei_pkg::RW_BIT]) begin
                              cur_byte      = mem[st.addr];
                              next_st.oe    = ~cur_byte[dmsei_pkg::MSB];
                              next_st.obyte = {cur_byte[6:0], 1'b0};
                              next_st.addr  = st.addr
                                              + dmsei_pkg::ADDR_STEP;
                              next_st.phase = dmsei_pkg::PH_READ;
                           end else begin
                              next_st.phase = dmsei_pkg::PH_ADDR;
                           end
                        end else begin
                           next_st.phase = dmsei_pkg::PH_IDLE;
                        end
                     end
                     dmsei_pkg::PH_ADDR: begin
                        next_st.addr  = st.shift[dmsei_pkg::ADDR_W-1:0];
                        next_st.phase = dmsei_pkg::PH_WDATA;
                     end
                     dmsei_pkg::PH_WDATA: begin
                        // Inhibited bytes are still acknowledged
                        if (wr_allow) begin
                           mem_we          = 1'b1;
                           next_st.wr_pend = 1'b1;
                           next_st.addr    = {st.addr[6:dmsei_pkg::PAGE_W],
                                              st.addr[dmsei_pkg::PAGE_W-1:0]
                                              + dmsei_pkg::PAGE_STEP};
                        end
                     end
                     dmsei_pkg::PH_READ: begin
                        if (st.mack) begin
                           cur_byte      = mem[st.addr];
                           next_st.oe    = ~cur_byte[dmsei_pkg::MSB];
                           next_st.obyte = {cur_byte[6:0], 1'b0};
                           next_st.addr  = st.addr
                                           + dmsei_pkg::ADDR_STEP;
                        end else begin
                           next_st.phase = dmsei_pkg::PH_IDLE;
                        end
                     end
                     default: begin
                        next_st.phase = dmsei_pkg::PH_IDLE;
                     end
                  endcase
               end else if (st.phase == dmsei_pkg::PH_READ
                            && st.bitcnt != dmsei_pkg::CNT_ZERO) begin
                  next_st.oe    = ~st.obyte[dmsei_pkg::MSB];
                  next_st.obyte = {st.obyte[6:0], 1'b0};
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Array is not reset: contents survive the power-on reset
   always_ff @(posedge core_clk_in) begin
      if (mem_we && rstn_in) begin
         mem[st.addr] <= st.shift;
      end
   end

   assign sda_out       = 1'b0;
   assign sda_oe_out    = st.oe;
   assign bus_mode_out  = (st.mode != dmsei_pkg::MODE_TX);
   assign prog_busy_out = st.busy;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_init_released: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in)
      (st.mode == dmsei_pkg::MODE_TX
       && st.tx_init < dmsei_pkg::INIT_PULSES) |-> !sda_oe_out)
      else $error("data driven during stream initialisation");

   chk_first_msb: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in)
      (st.mode == dmsei_pkg::MODE_TX && !scl_fall && transmit_only_clock_rise
       && st.tx_init == dmsei_pkg::INIT_PULSES
       && st.tx_bit == dmsei_pkg::CNT_ZERO
       && st.tx_addr == dmsei_pkg::ADDR_FIRST)
      |=> (sda_oe_out == !$past(mem[0][7])))
      else $error("first streamed bit is not msb of location zero");

   chk_dont_care_bit: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in)
      (st.mode == dmsei_pkg::MODE_TX
       && st.tx_bit == dmsei_pkg::CNT_ZERO) |-> !sda_oe_out)
      else $error("line driven during don't care bit");

   chk_bus_entry: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in)
      (st.mode == dmsei_pkg::MODE_TX && scl_fall)
      |=> (bus_mode_out && !sda_oe_out))
      else $error("bus clock fall did not leave stream mode");

   chk_bus_locked: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in)
      (st.mode == dmsei_pkg::MODE_BUS) |=> (st.mode == dmsei_pkg::MODE_BUS))
      else $error("locked bus mode was left");

   chk_recov_bound: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in)
      (st.mode == dmsei_pkg::MODE_TRANS && !scl_fall && !start_det
       && transmit_only_clock_rise && st.vcount == dmsei_pkg::RECOV_PULSES
                                    - dmsei_pkg::PULSE_STEP)
      |=> !bus_mode_out)
      else $error("transition state outlived its pulse budget");

   chk_recov_restart: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in)
      (st.mode == dmsei_pkg::MODE_TRANS && scl_fall)
      |=> (st.vcount == 8'h00 && st.rtimer == '0))
      else $error("transition counters not restarted");

   chk_write_gate: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in)
      mem_we |-> (wr_allow && st.phase == dmsei_pkg::PH_WDATA))
      else $error("memory written while writes are inhibited");

   chk_busy_refuse: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in)
      (st.busy && st.phase == dmsei_pkg::PH_DEV && scl_fall && !start_det
       && !stop_det && st.bitcnt == dmsei_pkg::ACK_BIT) |=> !sda_oe_out)
      else $error("select acknowledged during programming");

   chk_byte_ack: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in)
      ((st.phase == dmsei_pkg::PH_ADDR || st.phase == dmsei_pkg::PH_WDATA)
       && st.mode != dmsei_pkg::MODE_TX && !expire && scl_fall
       && !start_det && !stop_det && st.bitcnt == dmsei_pkg::ACK_BIT)
      |=> sda_oe_out ##1 sda_oe_out)
      else $error("received byte not acknowledged");

endmodule // dmsei_core

// ### dmsei_host.sv
// Display host model: two-wire bus master and stream clock source
`timescale 1ns/10ps
module dmsei_host (
   // Clock and resolved data wire
   input  wire logic core_clk_in,
   input  wire logic sda_line_in,
   // Driven pins, data is open drain
   output logic      scl_out,
   output logic      sda_drv_out,
   output logic      transmit_only_clock_out
);
   initial begin
      scl_out = 1'b1;
      sda_drv_out = 1'b1;
      transmit_only_clock_out = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask
   // Bus clock fall with no frame, used to leave stream mode
   task automatic scl_pulse();
      scl_out = 1'b0;
      hold(10);
      scl_out = 1'b1;
      hold(10);
   endtask
   task automatic set_transmit_only_clock(input logic v);
      transmit_only_clock_out = v;
   endtask
   // Eight core clocks a period, well above the input sync latency
   task automatic vpulse();
      transmit_only_clock_out = 1'b1;
      hold(4);
      transmit_only_clock_out = 1'b0;
      hold(4);
   endtask
   task automatic start();
      hold(5);
      sda_drv_out = 1'b1;
      hold(5);
      scl_out = 1'b1;
      hold(10);
      sda_drv_out = 1'b0;
      hold(10);
      scl_out = 1'b0;
   endtask
   task automatic stop();
      hold(5);
      sda_drv_out = 1'b0;
      hold(5);
      scl_out = 1'b1;
      hold(10);
      sda_drv_out = 1'b1;
      hold(10);
   endtask
   // Data changes mid low phase, sampled mid high phase
   task automatic xbit(input logic b, output logic r);
      hold(5);
      sda_drv_out = b;
      hold(5);
      scl_out = 1'b1;
      hold(5);
      r = sda_line_in;
      hold(5);
      scl_out = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic nack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xbit(d[i], r);
      end
      xbit(1'b1, nack);
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xbit(1'b1, r);
         d[i] = r;
      end
      xbit(last, r);
   endtask
endmodule // dmsei_host

// ### dual_mode_serial_eeprom_if_tb.sv
// Self-checking bench of the dual mode serial memory core
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module dual_mode_serial_eeprom_if_tb;
   logic       core_clk_in = 1'b0;
   logic       rstn_in = 1'b0;
   logic       scl, sda_drv, transmit_only_clock, sda_line;
   logic       sda_out, sda_oe_out, bus_mode_out, prog_busy_out;
   logic       nk;
   logic       wc = 1'b1;
   logic       p_sda_out, p_sda_oe, p_bus_mode, p_busy;
   logic [7:0] d;
   int         n_mismatch = 0;
   int         cmp_count = 0;
   logic [7:0] img [2] = '{8'hA5, 8'h3C};
   always #50 core_clk_in = ~core_clk_in;
   // Open drain wire with pull-up
   // Both variants share the wire; they hold the same contents throughout
   assign sda_line = sda_drv & (sda_oe_out ? sda_out : 1'b1)
                     & (p_sda_oe ? p_sda_out : 1'b1);
   dmsei_host host (.core_clk_in(core_clk_in), .sda_line_in(sda_line),
      .scl_out(scl), .sda_drv_out(sda_drv), .transmit_only_clock_out(transmit_only_clock));
   // Programming outlasts one select byte so a busy refusal can be seen
   dmsei_core #(.ERR_RECOVERY(1'b1), .WE_ON_TRANSMIT_ONLY_CLOCK(1'b1), .RECOV_CYCLES(4000),
      .PROG_CYCLES(400)) dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe_out(sda_oe_out), .transmit_only_clock_in(transmit_only_clock),
      .write_control_input_in(wc), .bus_mode_out(bus_mode_out),
      .prog_busy_out(prog_busy_out));
   dmsei_core #(.ERR_RECOVERY(1'b0), .WE_ON_TRANSMIT_ONLY_CLOCK(1'b0),
      .PROG_CYCLES(400)) dut_plain (.core_clk_in(core_clk_in),
      .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda_line),
      .sda_out(p_sda_out), .sda_oe_out(p_sda_oe),
      .transmit_only_clock_in(transmit_only_clock), .write_control_input_in(wc),
      .bus_mode_out(p_bus_mode), .prog_busy_out(p_busy));
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic do_reset();
      rstn_in = 1'b0;
      host.hold(6);
      rstn_in = 1'b1;
      host.hold(3);
   endtask
   task automatic hdr(input logic [7:0] a);
      host.start();
      host.wbyte(8'h60, nk);
      `CHK(nk, 1'b0)
      host.wbyte(a, nk);
   endtask
   task automatic rd_at(input logic [7:0] a);
      hdr(a);
      host.start();
      host.wbyte(8'h61, nk);
   endtask
   initial begin
      host.hold(40000);
      n_mismatch++;
      conclude();
   end
   initial begin
      do_reset();
      `CHK(bus_mode_out, 1'b0)
      repeat (9) begin host.vpulse(); `CHK(sda_oe_out, 1'b0) end
      host.scl_pulse();
      `CHK(bus_mode_out, 1'b1)
      `CHK(p_bus_mode, 1'b1)
      host.set_transmit_only_clock(1'b1);
      hdr(8'h00);
      host.wbyte(img[0], nk);
      host.wbyte(img[1], nk);
      `CHK(nk, 1'b0)
      host.stop();
      host.hold(3);
      `CHK(prog_busy_out, 1'b1)
      `CHK(p_busy, 1'b1)
      host.start();
      host.wbyte(8'h61, nk);
      `CHK(nk, 1'b1)
      host.stop();
      host.hold(250);
      `CHK(prog_busy_out, 1'b0)
      rd_at(8'h00);
      host.rbyte(1'b0, d);
      `CHK(d, img[0])
      host.rbyte(1'b1, d);
      `CHK(d, img[1])
      host.stop();
      // Writes inhibited by low enables: acked, never stored
      host.set_transmit_only_clock(1'b0);
      wc = 1'b0;
      hdr(8'h00);
      host.wbyte(8'h00, nk);
      `CHK(nk, 1'b0)
      host.stop();
      host.hold(3);
      `CHK(prog_busy_out, 1'b0)
      `CHK(p_busy, 1'b0)
      rd_at(8'h00);
      host.rbyte(1'b1, d);
      `CHK(d, img[0])
      host.stop();
      host.start();
      host.wbyte(8'h51, nk);
      `CHK(nk, 1'b1)
      host.stop();
      repeat (130) host.vpulse();
      `CHK(bus_mode_out, 1'b1)
      // Memory survives reset, stream restarts at location zero
      do_reset();
      `CHK(bus_mode_out, 1'b0)
      `CHK(p_bus_mode, 1'b0)
      repeat (9) begin host.vpulse(); `CHK(sda_oe_out, 1'b0) end
      for (int i = 0; i < 18; i++) begin
         host.vpulse();
         if (i % 9 == 8) `CHK(sda_oe_out, 1'b0)
         else `CHK(sda_oe_out, ~img[i / 9][7 - i % 9])
      end
      host.scl_pulse();
      repeat (127) host.vpulse();
      `CHK(bus_mode_out, 1'b1)
      host.vpulse();
      `CHK(bus_mode_out, 1'b0)
      `CHK(p_bus_mode, 1'b1)
      host.scl_pulse();
      repeat (100) host.vpulse();
      host.scl_pulse();
      repeat (100) host.vpulse();
      `CHK(bus_mode_out, 1'b1)
      host.hold(4100);
      `CHK(bus_mode_out, 1'b0)
      `CHK(p_bus_mode, 1'b1)
      conclude();
   end
endmodule // dual_mode_serial_eeprom_if_tb
